// file: eap_pkg.sv
/*
  constants, state encodings and the packed state record of the
  access-protection front end of a two-wire serial memory.
  assumes the user writes every reference as eap_pkg::name.
*/
package eap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // device codes and address layout
  localparam logic [4:0] EAP_MEM_CODE = 5'h15;
  localparam logic [6:0] EAP_PROTECT_RESET_N_CODE = 7'h5C;
  localparam logic [2:0] EAP_PROTECT_RESET_N_HI_ZERO = 3'h0;
  localparam logic [2:0] EAP_BLOCK0 = 3'h0;
  localparam logic [3:0] EAP_BITS = 4'h8;
  localparam logic [4:0] EAP_PROTECT_RESET_N_GLOBAL = 5'h08;
  localparam logic [4:0] EAP_PROTECT_RESET_N_WPN = 5'h09;
  localparam logic [4:0] EAP_PROTECT_RESET_N_SHARED = 5'h09;
  localparam logic [7:0] EAP_FILL_BYTE = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside a protection byte
  localparam int EAP_LOCK_POS = 7;
  localparam int EAP_RF_LSB = 4;
  localparam int EAP_PB_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // permission codes and reset values
  localparam logic [1:0] EAP_PERM_RW = 2'h3;
  localparam logic [1:0] EAP_PB_RST = 2'h3;
  localparam logic [1:0] EAP_RF_RST = 2'h3;
  localparam logic [7:0] EAP_WPN_RST = 8'hFF;
  localparam logic EAP_LOCK_RST = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    EAP_IDLE = 3'b000,
    EAP_RX = 3'b001,
    EAP_RX_ACK = 3'b010,
    EAP_TX = 3'b011,
    EAP_TX_ACK = 3'b100,
    EAP_SKIP = 3'b101
  } eap_state_t;

  typedef enum logic [1:0] {
    EAP_PH_DEV = 2'b00,
    EAP_PH_WORD = 2'b01,
    EAP_PH_DATA = 2'b10
  } eap_phase_t;

  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
  } eap_sync_t;

  typedef struct packed {
    eap_sync_t scl;
    eap_sync_t sda;
    eap_sync_t wp;
    eap_sync_t prn;
    logic scl_p;
    logic sda_p;
    eap_state_t st;
    eap_state_t after;
    eap_phase_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic oe;
    logic rd;
    logic protect_reset_n;
    logic [1:0] bsel;
    logic [9:0] ptr;
    logic [4:0] pptr;
    logic first;
    logic wr_any;
    logic mack;
    logic [7:0] lock;
    logic lock_ap;
    logic [7:0][1:0] pb;
    logic [7:0][1:0] rf;
    logic [1:0] page_wide_permission_field;
    logic [7:0] page_write_enable_bits;
    logic [10:0] maddr;
    logic mwr;
    logic [7:0] mwdata;
    logic prog;
  } eap_regs_t;

endpackage

// file: eap_access_protection.sv
/*
  two-wire serial slave front end with block permissions, sticky locks,
  block 0 page write enables and the chip-wide write-protect pin.
  assumes an external array answers mem_rdata_in for mem_addr_out within
  one clock, and raises prog_busy_in while a program cycle runs.
*/
`timescale 1ns/10ps

// Contract
// - reads increment low seven pointer bits only
// - write-protect pin high refuses every write
// - protection bits live in separately coded page
// - radio fields stored only, no serial effect
// - disallowed serial access answered with nack
// - field 0x none, 10 read, 11 full
// - cleared lock freezes that block's field
// - locks forced to one under protect reset
// - serial writes only clear locks; reads harmless
// - reads keep block latched by last write
// - write to locked byte acked, unchanged, no program
// - read-only block nacks write data, no program
// - no-access block nacks data and read address
// - shared page bytes checked against page-wide field
// - block 0 pages need enable bit and 11
// - lock never gates the block's data writes
// - blocks 1 to 7 have no page gating
// - protection codes take single bytes only
// - byte layout lock bit 7, field bits 1:0
// - protect reset low holds serial port reset
// - no address ack while program cycle runs
module eap_access_protection (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic wp_in,
  input wire logic protect_reset_n_in,
  input wire logic prog_busy_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [10:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_wr_out,
  output logic prog_start_out
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // three-stage pin filter: level moves once stages two and three agree
  function automatic eap_pkg::eap_sync_t sync_step(input eap_pkg::eap_sync_t s,
                                                   input logic pin);
    eap_pkg::eap_sync_t r;
    r = s;
    r.sh = {s.sh[1:0], pin};
    if (s.sh[1] == s.sh[2]) begin
      r.lvl = s.sh[2];
    end
    return r;
  endfunction

  function automatic logic [1:0] perm_of(input eap_pkg::eap_regs_t r,
                                         input logic [2:0] blk);
    return r.pb[blk];
  endfunction

  function automatic logic protect_reset_n_readable(input eap_pkg::eap_regs_t r);
    logic ok;
    ok = 1'b1;
    if (r.pptr >= eap_pkg::EAP_PROTECT_RESET_N_SHARED) begin
      ok = r.page_wide_permission_field[1];
    end
    return ok;
  endfunction

  function automatic logic [10:0] rd_addr(input eap_pkg::eap_regs_t r);
    logic [10:0] a;
    a = {1'b0, r.ptr};
    if (r.protect_reset_n) begin
      a = {1'b1, 5'h00, r.pptr};
    end
    return a;
  endfunction

  function automatic logic [7:0] rd_byte(input eap_pkg::eap_regs_t r,
                                         input logic [7:0] mem);
    logic [7:0] b;
    b = mem;
    if (r.protect_reset_n && !r.first) begin
      b = eap_pkg::EAP_FILL_BYTE;
    end else if (r.protect_reset_n && r.pptr < eap_pkg::EAP_PROTECT_RESET_N_GLOBAL) begin
      b = 8'h00;
      b[eap_pkg::EAP_LOCK_POS] = r.lock[r.pptr[2:0]];
      b[eap_pkg::EAP_RF_LSB +: 2] = r.rf[r.pptr[2:0]];
      b[eap_pkg::EAP_PB_LSB +: 2] = r.pb[r.pptr[2:0]];
    end else if (r.protect_reset_n && r.pptr == eap_pkg::EAP_PROTECT_RESET_N_GLOBAL) begin
      b = 8'h00;
      b[eap_pkg::EAP_LOCK_POS] = r.lock_ap;
      b[eap_pkg::EAP_PB_LSB +: 2] = r.page_wide_permission_field;
    end else if (r.protect_reset_n && r.pptr == eap_pkg::EAP_PROTECT_RESET_N_WPN) begin
      b = r.page_write_enable_bits;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  eap_pkg::eap_regs_t q;
  eap_pkg::eap_regs_t d;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = q.scl.lvl & ~q.scl_p;
  assign scl_fall = ~q.scl.lvl & q.scl_p;
  assign start_seen = q.scl.lvl & q.scl_p & ~q.sda.lvl & q.sda_p;
  assign stop_seen = q.scl.lvl & q.scl_p & q.sda.lvl & ~q.sda_p;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic mem_hit;
    logic protect_reset_n_hit;
    logic ok;
    logic [7:0] nb;
    logic [2:0] idx;
    logic [1:0] perm;
    mem_hit = 1'b0;
    perm = 2'h0;
    protect_reset_n_hit = 1'b0;
    ok = 1'b0;
    nb = 8'h00;
    idx = 3'h0;
    d = q;
    d.scl = sync_step(q.scl, scl_in);
    d.sda = sync_step(q.sda, sda_in);
    d.wp = sync_step(q.wp, wp_in);
    d.prn = sync_step(q.prn, protect_reset_n_in);
    d.scl_p = q.scl.lvl;
    d.sda_p = q.sda.lvl;
    d.mwr = 1'b0;
    d.prog = 1'b0;
    d.maddr = rd_addr(q);
    nb = rd_byte(q, mem_rdata_in);
    if (!q.prn.lvl) begin
      d.lock = '1;
      d.lock_ap = eap_pkg::EAP_LOCK_RST;
      d.st = eap_pkg::EAP_IDLE;
      d.oe = 1'b0;
      d.wr_any = 1'b0;
    end else if (start_seen) begin
      d.st = eap_pkg::EAP_RX;
      d.ph = eap_pkg::EAP_PH_DEV;
      d.cnt = 4'h0;
      d.oe = 1'b0;
    end else if (stop_seen) begin
      d.st = eap_pkg::EAP_IDLE;
      d.oe = 1'b0;
      d.prog = q.wr_any;
      d.wr_any = 1'b0;
    end else begin
      unique case (q.st)
        eap_pkg::EAP_IDLE, eap_pkg::EAP_SKIP: begin
        end
        eap_pkg::EAP_RX: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], q.sda.lvl};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == eap_pkg::EAP_BITS) begin
            d.st = eap_pkg::EAP_RX_ACK;
            d.after = eap_pkg::EAP_RX;
            unique case (q.ph)
              eap_pkg::EAP_PH_DEV: begin
                mem_hit = q.sh[7:3] == eap_pkg::EAP_MEM_CODE;
                protect_reset_n_hit = q.sh[7:1] == eap_pkg::EAP_PROTECT_RESET_N_CODE;
                if (!(mem_hit || protect_reset_n_hit) || prog_busy_in) begin
                  d.st = eap_pkg::EAP_SKIP;
                end else if (q.sh[0]) begin
                  d.protect_reset_n = protect_reset_n_hit;
                  d.rd = 1'b1;
                  d.first = 1'b1;
                  if (protect_reset_n_hit) begin
                    ok = protect_reset_n_readable(q);
                  end else begin
                    perm = perm_of(q, q.ptr[9:7]);
                    ok = perm[1];
                  end
                  d.oe = ok;
                  d.after = ok ? eap_pkg::EAP_TX : eap_pkg::EAP_SKIP;
                end else begin
                  d.protect_reset_n = protect_reset_n_hit;
                  d.rd = 1'b0;
                  d.bsel = q.sh[2:1];
                  d.ph = eap_pkg::EAP_PH_WORD;
                  d.oe = 1'b1;
                end
              end
              eap_pkg::EAP_PH_WORD: begin
                ok = 1'b1;
                if (q.protect_reset_n) begin
                  ok = q.sh[7:5] == eap_pkg::EAP_PROTECT_RESET_N_HI_ZERO;
                  d.pptr = q.sh[4:0];
                end else begin
                  d.ptr = {q.bsel, q.sh};
                end
                d.first = 1'b1;
                d.ph = eap_pkg::EAP_PH_DATA;
                d.oe = ok;
                d.after = ok ? eap_pkg::EAP_RX : eap_pkg::EAP_SKIP;
              end
              eap_pkg::EAP_PH_DATA: begin
                if (q.protect_reset_n) begin
                  if (!q.first) begin
                    ok = 1'b0;
                  end else if (q.wp.lvl) begin
                    ok = 1'b0;
                  end else if (q.pptr < eap_pkg::EAP_PROTECT_RESET_N_GLOBAL) begin
                    ok = 1'b1;
                    idx = q.pptr[2:0];
                    if (q.lock[idx]) begin
                      d.lock[idx] = q.lock[idx] & q.sh[eap_pkg::EAP_LOCK_POS];
                      d.pb[idx] = q.sh[eap_pkg::EAP_PB_LSB +: 2];
                      d.rf[idx] = q.sh[eap_pkg::EAP_RF_LSB +: 2];
                      d.wr_any = 1'b1;
                    end
                  end else if (q.pptr == eap_pkg::EAP_PROTECT_RESET_N_GLOBAL) begin
                    ok = 1'b1;
                    if (q.lock_ap) begin
                      d.lock_ap = q.lock_ap & q.sh[eap_pkg::EAP_LOCK_POS];
                      d.page_wide_permission_field = q.sh[eap_pkg::EAP_PB_LSB +: 2];
                      d.wr_any = 1'b1;
                    end
                  end else begin
                    ok = q.page_wide_permission_field == eap_pkg::EAP_PERM_RW;
                    if (ok && q.pptr == eap_pkg::EAP_PROTECT_RESET_N_WPN) begin
                      d.page_write_enable_bits = q.sh;
                      d.wr_any = 1'b1;
                    end else if (ok) begin
                      d.mwr = 1'b1;
                      d.maddr = {1'b1, 5'h00, q.pptr};
                      d.mwdata = q.sh;
                      d.wr_any = 1'b1;
                    end
                  end
                end else begin
                  // lock bits take no part here
                  perm = perm_of(q, q.ptr[9:7]);
                  ok = !q.wp.lvl && perm == eap_pkg::EAP_PERM_RW;
                  if (q.ptr[9:7] == eap_pkg::EAP_BLOCK0) begin
                    ok = ok && q.page_write_enable_bits[q.ptr[6:4]];
                  end
                  if (ok) begin
                    d.mwr = 1'b1;
                    d.maddr = {1'b0, q.ptr};
                    d.mwdata = q.sh;
                    d.ptr[3:0] = q.ptr[3:0] + 4'h1;
                    d.wr_any = 1'b1;
                  end
                end
                if (!ok) begin
                  d.wr_any = 1'b0;
                end
                d.first = 1'b0;
                d.oe = ok;
                d.after = ok ? eap_pkg::EAP_RX : eap_pkg::EAP_SKIP;
              end
              default: begin
                d.st = eap_pkg::EAP_SKIP;
              end
            endcase
          end
        end
        eap_pkg::EAP_RX_ACK: begin
          if (scl_fall) begin
            d.oe = 1'b0;
            d.st = q.after;
            d.cnt = 4'h0;
            if (q.after == eap_pkg::EAP_TX) begin
              d.sh = nb;
              d.oe = ~nb[7];
            end
          end
        end
        eap_pkg::EAP_TX: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == eap_pkg::EAP_BITS) begin
            d.oe = 1'b0;
            d.st = eap_pkg::EAP_TX_ACK;
            if (q.protect_reset_n) begin
              d.first = 1'b0;
            end else begin
              d.ptr[6:0] = q.ptr[6:0] + 7'h01;
            end
          end else if (scl_fall) begin
            d.sh = {q.sh[6:0], 1'b1};
            d.oe = ~q.sh[6];
          end
        end
        eap_pkg::EAP_TX_ACK: begin
          if (scl_rise) begin
            d.mack = ~q.sda.lvl;
          end else if (scl_fall) begin
            d.cnt = 4'h0;
            if (q.mack) begin
              d.st = eap_pkg::EAP_TX;
              d.sh = nb;
              d.oe = ~nb[7];
            end else begin
              d.st = eap_pkg::EAP_SKIP;
            end
          end
        end
        default: begin
          d.st = eap_pkg::EAP_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
    if (rst_in) begin
      d = '0;
      d.scl.sh = 3'h7;
      d.scl.lvl = 1'b1;
      d.sda.sh = 3'h7;
      d.sda.lvl = 1'b1;
      d.wp.sh = 3'h7;
      d.wp.lvl = 1'b1;
      d.scl_p = 1'b1;
      d.sda_p = 1'b1;
      d.lock = '1;
      d.lock_ap = eap_pkg::EAP_LOCK_RST;
      d.pb = {8{eap_pkg::EAP_PB_RST}};
      d.rf = {8{eap_pkg::EAP_RF_RST}};
      d.page_wide_permission_field = eap_pkg::EAP_PB_RST;
      d.page_write_enable_bits = eap_pkg::EAP_WPN_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and outputs

  always_ff @(posedge clk_in) begin
    q <= d;
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = q.oe;
  assign mem_addr_out = q.maddr;
  assign mem_wdata_out = q.mwdata;
  assign mem_wr_out = q.mwr;
  assign prog_start_out = q.prog;

endmodule

// file: eap_master.sv
/*
  behavioural two-wire bus master: drives the serial clock, pulls data low.
  assumes sda_in is the wired level of both parties with a pull-up.
*/
`timescale 1ns/10ps
module eap_master (
  output logic scl_out,
  output logic sda_oe_out,
  input wire logic sda_in
);
  localparam realtime Q = 31.25;

  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  ////////////////////////////////////////
  // the clock stands high between frames
  task automatic start_c();
    #Q sda_oe_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_oe_out = 1'b1;
    #Q scl_out = 1'b0;
  endtask

  task automatic stop_c();
    #Q sda_oe_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_oe_out = 1'b0;
    #250;
  endtask

  // nine bits, msb first; a one releases the line so the slave can answer
  task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #Q sda_oe_out = !d[i];
      #Q scl_out = 1'b1;
      #Q r[i] = sda_in;
      #Q scl_out = 1'b0;
    end
  endtask
endmodule

// file: eap_access_protection_chk.sv
/*
  port assertions of the access-protection slave.
  assumes binding to eap_access_protection, one clock domain.
*/
`timescale 1ns/10ps
module eap_access_protection_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic wp_in,
  input wire logic protect_reset_n_in,
  input wire logic prog_busy_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [10:0] mem_addr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic mem_wr_out,
  input wire logic prog_start_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_protect_reset_n_low;
    !protect_reset_n_in [*8];
  endsequence
  sequence s_wp_high;
    wp_in [*8];
  endsequence

  ////////////////////////////////////////
  property p_rst_quiet;
    disable iff (1'b0) rst_in |=> !sda_oe_out && !mem_wr_out && !prog_start_out;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_protect_reset_n_idle;
    s_protect_reset_n_low |-> !sda_oe_out && !mem_wr_out && !prog_start_out;
  endproperty
  a_protect_reset_n_idle: assert property (p_protect_reset_n_idle) else $error("active under protect reset");
  property p_wp_no_wr;
    s_wp_high |-> !mem_wr_out;
  endproperty
  a_wp_no_wr: assert property (p_wp_no_wr) else $error("array write while protected");
  property p_wr_range;
    mem_wr_out |-> !mem_addr_out[10] || mem_addr_out[4:0] >= 5'h0A;
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("protection byte sent to array");
  property p_wr_pulse;
    mem_wr_out |=> !mem_wr_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_prog_pulse;
    prog_start_out |=> !prog_start_out [*2];
  endproperty
  a_prog_pulse: assert property (p_prog_pulse) else $error("program start too long");
  property p_prog_idle;
    prog_start_out |-> scl_in && sda_in;
  endproperty
  a_prog_idle: assert property (p_prog_idle) else $error("program start on busy bus");
  property p_sda_const;
    sda_out == 1'b0;
  endproperty
  a_sda_const: assert property (p_sda_const) else $error("data pin value not low");
endmodule

bind eap_access_protection eap_access_protection_chk u_chk (.clk_in, .rst_in, .scl_in, .sda_in,
  .sda_out, .sda_oe_out, .wp_in, .protect_reset_n_in, .prog_busy_in, .mem_rdata_in,
  .mem_addr_out, .mem_wdata_out, .mem_wr_out, .prog_start_out);

// file: test_eap_access_protection.sv
/*
  self-checking bench of the access-protection slave.
  assumes eap_master on the bus and an array that answers from the address.
*/
`timescale 1ns/10ps
module test_eap_access_protection;
  logic clk_in, rst_in, wp_in, protect_reset_n_in, prog_busy_in;
  logic scl, m_oe, d_oe, wr, pg;
  logic [10:0] maddr;
  logic [7:0] rdata, wd, w;
  logic [9:0] a;
  logic [2:0] k;
  logic [31:0] seed = 32'h0000BB7B;
  int fail_count = 0;
  int tests_run = 0;
  int cnt_q = 0;
  int n;
  wire sda_w;
  localparam logic [7:0] PW = {eap_pkg::EAP_PROTECT_RESET_N_CODE, 1'b0};
  localparam logic [7:0] PR = {eap_pkg::EAP_PROTECT_RESET_N_CODE, 1'b1};

  assign sda_w = !(m_oe | d_oe);
  assign rdata = maddr[7:0] ^ {maddr[9:8], 6'h15};
  eap_master u_m (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda_w));
  eap_access_protection u_dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(), .sda_oe_out(d_oe), .wp_in(wp_in),
    .protect_reset_n_in(protect_reset_n_in), .prog_busy_in(prog_busy_in),
    .mem_rdata_in(rdata), .mem_addr_out(maddr), .mem_wdata_out(wd), .mem_wr_out(wr),
    .prog_start_out(pg));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // array writes count 1, program starts count 16
  always @(posedge clk_in) begin
    if (wr === 1'b1) cnt_q += 1;
    if (pg === 1'b1) cnt_q += 16;
  end

  ////////////////////////////////////////
  function automatic logic [7:0] ev(input logic [9:0] x);
    return x[7:0] ^ {x[9:8], 6'h15};
  endfunction
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send_b(input logic [7:0] b, input logic ack);
    logic [8:0] r;
    u_m.xbyte({b, 1'b1}, r);
    chk({7'h0, !r[0]}, {7'h0, ack});
  endtask
  task automatic recv_b(input logic last, input logic [7:0] exp);
    logic [8:0] r;
    u_m.xbyte({8'hFF, last}, r);
    chk(r[8:1], exp);
  endtask
  task automatic setp(input logic [7:0] dev, input logic [7:0] wa);
    u_m.start_c();
    send_b(dev, 1'b1);
    send_b(wa, 1'b1);
  endtask
  task automatic pw(input logic [4:0] wa, input logic [7:0] d, input logic ack);
    setp(PW, {3'h0, wa});
    send_b(d, ack);
    u_m.stop_c();
  endtask
  task automatic pr(input logic [4:0] wa, input logic [7:0] exp);
    setp(PW, {3'h0, wa});
    u_m.start_c();
    send_b(PR, 1'b1);
    recv_b(1'b1, exp);
    u_m.stop_c();
  endtask
  task automatic mw(input logic [9:0] x, input logic [7:0] d, input logic ack);
    setp({eap_pkg::EAP_MEM_CODE, x[9:8], 1'b0}, x[7:0]);
    send_b(d, ack);
    u_m.stop_c();
  endtask
  task automatic rdm(input logic [9:0] x, input logic ack, input logic [7:0] exp);
    setp({eap_pkg::EAP_MEM_CODE, x[9:8], 1'b0}, x[7:0]);
    u_m.start_c();
    send_b({eap_pkg::EAP_MEM_CODE, ~x[9:8], 1'b1}, ack);
    if (ack) recv_b(1'b1, exp);
    u_m.stop_c();
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #600000;
    fail_count++;
    stop_test();
  end

  ////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    wp_in = 1'b0;
    protect_reset_n_in = 1'b1;
    prog_busy_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (20) tick();
    a = 10'(rnd());
    a[6:0] = 7'h7E;
    setp({eap_pkg::EAP_MEM_CODE, a[9:8], 1'b0}, a[7:0]);
    u_m.start_c();
    send_b({eap_pkg::EAP_MEM_CODE, ~a[9:8], 1'b1}, 1'b1);
    for (int i = 0; i < 3; i++) begin
      recv_b(i == 2, ev({a[9:7], 7'(a[6:0] + i)}));
    end
    u_m.stop_c();
    for (int p = 0; p < 4; p++) begin
      k = 3'(rnd() % 7 + 1);
      pw({2'h0, k}, 8'(8'hA0 + p), 1'b1);
      pr({2'h0, k}, 8'(8'hA0 + p));
      a = {k, 7'(rnd())};
      n = cnt_q;
      mw(a, 8'(rnd()), p == 3);
      chk(8'(cnt_q - n), (p == 3) ? 8'h11 : 8'h00);
      rdm(a, p > 1, ev(a));
      if (p < 2) begin
        setp({eap_pkg::EAP_MEM_CODE, a[9:8], 1'b0}, a[7:0]);
        u_m.stop_c();
        u_m.start_c();
        send_b({eap_pkg::EAP_MEM_CODE, a[9:8], 1'b1}, 1'b0);
        u_m.stop_c();
      end
    end
    w = 8'(rnd());
    setp(PW, 8'h09);
    send_b(w, 1'b1);
    send_b(w, 1'b0);
    u_m.stop_c();
    for (int p = 0; p < 8; p++) begin
      mw({3'h0, 3'(p), 4'(rnd())}, 8'h33, w[p]);
    end
    pw(5'h08, 8'h82, 1'b1);
    pw(5'h09, 8'h00, 1'b0);
    pr(5'h09, w);
    pw(5'h08, 8'h83, 1'b1);
    n = cnt_q;
    pw(5'h12, 8'h5A, 1'b1);
    chk(8'(cnt_q - n), 8'h11);
    pr(5'h12, ev(10'h012));
    u_m.start_c();
    send_b(PW, 1'b1);
    send_b(8'h20, 1'b0);
    u_m.stop_c();
    tick();
    wp_in = 1'b1;
    a = {k, 7'(rnd())};
    mw(a, 8'h11, 1'b0);
    rdm(a, 1'b1, ev(a));
    pw(5'h09, 8'h00, 1'b0);
    tick();
    wp_in = 1'b0;
    pw({2'h0, k}, 8'h03, 1'b1);
    n = cnt_q;
    pw({2'h0, k}, 8'hB2, 1'b1);
    chk(8'(cnt_q - n), 8'h00);
    pr({2'h0, k}, 8'h03);
    mw({k, 7'(rnd())}, 8'h77, 1'b1);
    chk(wd, 8'h77);
    tick();
    protect_reset_n_in = 1'b0;
    u_m.start_c();
    send_b(PW, 1'b0);
    u_m.stop_c();
    tick();
    protect_reset_n_in = 1'b1;
    repeat (20) tick();
    pr({2'h0, k}, 8'h83);
    tick();
    prog_busy_in = 1'b1;
    u_m.start_c();
    send_b(PW, 1'b0);
    u_m.stop_c();
    stop_test();
  end
endmodule
